// ==== tti_defs.svh ====
// Register offsets, field positions, reset values and counts of the timer and tick interrupt logic.
`ifndef TTI_DEFS_SVH
`define TTI_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TTI_OFS_IRQ_CTRL   4'h0
`define TTI_OFS_TICK_DIV   4'h4
`define TTI_OFS_TIMER_CTRL 4'h8
`define TTI_OFS_STATUS     4'hC

// ****************************************************************
// Field positions
// ****************************************************************
`define TTI_BIT_GIE        0
`define TTI_BIT_TIMER_EN   1
`define TTI_BIT_TIMER_FLAG 2
`define TTI_BIT_TICK_EN    3
`define TTI_BIT_TICK_FLAG  4
`define TTI_BIT_TICK_SEL   0
`define TTI_PERIOD_LSB     4
`define TTI_PERIOD_MASK    8'h30
`define TTI_BIT_IN_SERVICE 0
`define TTI_BIT_STACK_FULL 1
`define TTI_BIT_SLEEP      2

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define TTI_PERIOD_RESET   2'h0
`define TTI_TICK_BASE      1024
`define TTI_VEC_TIMER      12'h0008
`define TTI_VEC_TICK       12'h000C

`endif

// ==== tti_pkg.sv ====
// Types shared by the timer and tick interrupt logic.
package tti_pkg;

   // Signals that the processor core hands to the interrupt logic.
   typedef struct packed {
      logic stack_full;
      logic ret;
      logic return_from_irq;
      logic sleep;
   } tti_core_t;

   // Vector call that the interrupt logic issues to the core.
   typedef struct packed {
      logic        valid;
      logic [11:0] vector;
   } tti_call_t;

   // Service tracking state.
   typedef enum logic {
      TTI_RUN,
      TTI_SERVICE
   } tti_state_t;

endpackage

// ==== tti_tick_divider.sv ====
// Periodic tick divider with selectable source clock and period.
`timescale 1ns/10ps
`default_nettype none
`include "tti_defs.svh"
module tti_tick_divider #(
   parameter int BASE_CYCLES = `TTI_TICK_BASE
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sub_clk_pin,
   input  wire logic       clock_select,
   input  wire logic [1:0] period_select,
   output var  logic       tick_overflow
);
   import tti_pkg::*;

   localparam int CNT_W = $clog2(BASE_CYCLES * 8);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   // A base below two leaves no room for the wrap compare.
   generate
      if (BASE_CYCLES < 2) begin : g_bad_base
         $error("tti_tick_divider: BASE_CYCLES must be at least 2");
      end
   endgenerate

   // Last count of a period: base times one, two, four or eight, minus one.
   function automatic logic [CNT_W-1:0] last_count(input logic [1:0] sel);
      last_count = CNT_W'((BASE_CYCLES << sel) - 1);
   endfunction

   logic             sub_meta;
   logic             sub_sync;
   logic             sub_prev;
   logic [CNT_W-1:0] count;

   // Sub clock pin passes three flip-flops; the edge detect looks at the second and third.
   always_ff @(posedge clk) begin
      sub_meta <= sub_clk_pin;
      sub_sync <= sub_meta;
      sub_prev <= sub_sync;
   end

   // One source step per system clock, or per rising sub clock edge.
   wire              sub_edge  = sub_sync & ~sub_prev;
   wire              src_step  = clock_select ? sub_edge : 1'b1;
   // Greater-or-equal so that shortening the period never strands the count.
   wire              at_last   = (count >= last_count(period_select));
   wire [CNT_W-1:0]  next_count = at_last ? '0 : count + 1'b1;

   // Counter and overflow pulse.
   always_ff @(posedge clk) begin
      if (rst) begin
         count         <= '0;
         tick_overflow <= 1'b0;
      end else begin
         if (src_step) begin
            count <= next_count;
         end
         tick_overflow <= src_step & at_last;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_TICK_PERIOD: assert property (tick_overflow |-> $past(count) >= last_count($past(period_select)))
      else $error("tick overflow at wrong count");
   AST_SYS_SOURCE: assert property (!clock_select && !at_last |=> count == $past(count) + 1'b1)
      else $error("system clock source did not step the divider");
endmodule
`default_nettype wire

// ==== tti_timer_tick_irq.sv ====
// Interrupt request logic for the timer overflow and periodic tick sources.
`timescale 1ns/10ps
`default_nettype none
`include "tti_defs.svh"
module tti_timer_tick_irq #(
   parameter int          TICK_BASE_CYCLES = `TTI_TICK_BASE,
   parameter logic [11:0] TIMER_VECTOR     = `TTI_VEC_TIMER,
   parameter logic [11:0] TICK_VECTOR      = `TTI_VEC_TICK
) (
   input  wire logic               SYS_CLK,
   input  wire logic               SYS_RST,
   input  wire logic [3:0]         AVS_ADDRESS,
   input  wire logic               AVS_READ,
   input  wire logic               AVS_WRITE,
   input  wire logic [31:0]        AVS_WRITEDATA,
   input  wire logic [3:0]         AVS_BYTEENABLE,
   output var  logic [31:0]        AVS_READDATA,
   output var  logic               AVS_WAITREQUEST,
   input  wire logic               TIMER_OVERFLOW,
   input  wire logic               SUB_CLK_PIN,
   input  wire tti_pkg::tti_core_t CORE,
   output var  tti_pkg::tti_call_t CALL,
   output var  logic               WAKE
);
   import tti_pkg::*;

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   generate
      if (TIMER_VECTOR == TICK_VECTOR) begin : g_bad_vec
         $error("tti_timer_tick_irq: the two vectors must differ");
      end
   endgenerate

   // ****************************************************************
   // State
   // ****************************************************************
   logic       global_irq_enable;
   logic       timer_irq_enable;
   logic       timer_irq_flag;
   logic       tick_irq_enable;
   logic       tick_irq_flag;
   logic       tick_clock_select;
   logic [1:0] tick_period_select;
   tti_state_t state;
   logic       tick_overflow;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // A request is answered one cycle after it is first seen; the access itself
   // happens on the edge where waitrequest is low.
   wire       bus_req     = AVS_READ | AVS_WRITE;
   wire       bus_load    = AVS_READ & AVS_WAITREQUEST;
   wire       sw_wr       = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
   wire       wr_ctrl     = sw_wr & (AVS_ADDRESS == `TTI_OFS_IRQ_CTRL);
   wire       wr_div      = sw_wr & (AVS_ADDRESS == `TTI_OFS_TICK_DIV);
   wire       wr_tmr      = sw_wr & (AVS_ADDRESS == `TTI_OFS_TIMER_CTRL);
   wire [7:0] wd          = AVS_WRITEDATA[7:0];

   // Read values; unmapped offsets and unused bits read as zero.
   wire [7:0] rd_ctrl     = {3'h0, tick_irq_flag, tick_irq_enable, timer_irq_flag,
                             timer_irq_enable, global_irq_enable};
   wire [7:0] rd_div      = {2'h0, tick_period_select, 4'h0};
   wire [7:0] rd_tmr      = {7'h00, tick_clock_select};
   wire [7:0] rd_stat     = {5'h00, CORE.sleep, CORE.stack_full, state == TTI_SERVICE};
   wire [7:0] rd_value    = (AVS_ADDRESS == `TTI_OFS_IRQ_CTRL)   ? rd_ctrl :
                            (AVS_ADDRESS == `TTI_OFS_TICK_DIV)   ? rd_div  :
                            (AVS_ADDRESS == `TTI_OFS_TIMER_CTRL) ? rd_tmr  :
                            (AVS_ADDRESS == `TTI_OFS_STATUS)     ? rd_stat : 8'h00;

   // Bus answer registers. Read data is captured on the first edge of a read,
   // so a master sees the register as it stood one cycle before the accept edge.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h0000_0000;
      end else begin
         AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
         if (bus_load) begin
            AVS_READDATA <= {24'h00_0000, rd_value};
         end
      end
   end

   // ****************************************************************
   // Vector selection
   // ****************************************************************
   // The stack-full input blocks every acknowledge, enabled or not; the core
   // lowers it only after popping, so a held request is served afterwards.
   wire stack_free  = ~CORE.stack_full;
   wire timer_ready = global_irq_enable & timer_irq_enable & timer_irq_flag;
   wire tick_ready  = global_irq_enable & tick_irq_enable & tick_irq_flag;
   // Timer first; clearing the global enable on the call stops the tick from
   // following in the next cycle unless software re-enables nesting.
   wire take_timer  = timer_ready & stack_free;
   wire take_tick   = tick_ready & stack_free & ~timer_ready;
   wire take_any    = take_timer | take_tick;

   // ****************************************************************
   // Next flag values
   // ****************************************************************
   // Hardware set beats both the software clear and the service clear. A
   // software write of one also sets the flag, which is how a source is kept
   // from waking the part.
   wire next_timer_flag = TIMER_OVERFLOW |
                          (wr_ctrl ? wd[`TTI_BIT_TIMER_FLAG]
                                   : (timer_irq_flag & ~take_timer));
   wire next_tick_flag  = tick_overflow |
                          (wr_ctrl ? wd[`TTI_BIT_TICK_FLAG]
                                   : (tick_irq_flag & ~take_tick));
   // Entry clears the global enable; a return from interrupt sets it; a plain
   // return leaves it alone.
   wire next_gie        = take_any ? 1'b0 :
                          CORE.return_from_irq ? 1'b1 :
                          wr_ctrl ? wd[`TTI_BIT_GIE] : global_irq_enable;
   wire flag_rise       = (next_timer_flag & ~timer_irq_flag) | (next_tick_flag & ~tick_irq_flag);

   // ****************************************************************
   // Interrupt control register
   // ****************************************************************
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         global_irq_enable <= 1'b0;
         timer_irq_enable  <= 1'b0;
         timer_irq_flag    <= 1'b0;
         tick_irq_enable   <= 1'b0;
         tick_irq_flag     <= 1'b0;
      end else begin
         global_irq_enable <= next_gie;
         timer_irq_flag    <= next_timer_flag;
         tick_irq_flag     <= next_tick_flag;
         if (wr_ctrl) begin
            timer_irq_enable <= wd[`TTI_BIT_TIMER_EN];
            tick_irq_enable  <= wd[`TTI_BIT_TICK_EN];
         end
      end
   end

   // ****************************************************************
   // Tick configuration registers
   // ****************************************************************
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         tick_period_select <= `TTI_PERIOD_RESET;
         tick_clock_select  <= 1'b0;
      end else begin
         if (wr_div) begin
            tick_period_select <= wd[`TTI_PERIOD_LSB +: 2];
         end
         if (wr_tmr) begin
            tick_clock_select <= wd[`TTI_BIT_TICK_SEL];
         end
      end
   end

   // ****************************************************************
   // Vector call, service state and wake-up
   // ****************************************************************
   // Only the vector is handed over; the core pushes the program counter and
   // the handler must save anything else it touches.
   // The flag logic runs on this clock, so in a stopped-oscillator mode the
   // clock feeding this block must be kept alive for wake-up to work.
   // A return in the cycle of a new call keeps the service state, as a new handler opens.
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         CALL  <= '0;
         WAKE  <= 1'b0;
         state <= TTI_RUN;
      end else begin
         CALL.valid  <= take_any;
         CALL.vector <= take_timer ? TIMER_VECTOR : (take_tick ? TICK_VECTOR : 12'h000);
         WAKE        <= CORE.sleep & flag_rise;
         case (state)
            TTI_RUN: begin
               if (take_any) begin
                  state <= TTI_SERVICE;
               end
            end
            TTI_SERVICE: begin
               if ((CORE.ret | CORE.return_from_irq) & ~take_any) begin
                  state <= TTI_RUN;
               end
            end
            default: begin
               state <= TTI_RUN;
            end
         endcase
      end
   end

   // ****************************************************************
   // Tick divider
   // ****************************************************************
   // The divider runs all the time; the tick enable, with the global enable and a free stack, decides whether it raises a vector call.
   tti_tick_divider #(
      .BASE_CYCLES   (TICK_BASE_CYCLES)
   ) u_tick_divider (
      .clk           (SYS_CLK),
      .rst           (SYS_RST),
      .sub_clk_pin   (SUB_CLK_PIN),
      .clock_select  (tick_clock_select),
      .period_select (tick_period_select),
      .tick_overflow (tick_overflow)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   sequence timer_call_s;
      CALL.valid && CALL.vector == TIMER_VECTOR;
   endsequence
   sequence tick_call_s;
      CALL.valid && CALL.vector == TICK_VECTOR;
   endsequence
   sequence gated_timer_s;
      global_irq_enable && timer_irq_enable && timer_irq_flag && !CORE.stack_full;
   endsequence

   AST_TIMER_GATED: assert property (timer_call_s |-> $past(global_irq_enable && timer_irq_enable
                                     && timer_irq_flag))
      else $error("timer vector called without both enables");
   AST_TIMER_CALLED: assert property (gated_timer_s |=> timer_call_s ##0 !global_irq_enable)
      else $error("enabled timer request not called");
   AST_TIMER_FLAG_SET: assert property (TIMER_OVERFLOW |=> timer_irq_flag)
      else $error("timer overflow did not set the flag");
   AST_TIMER_CLEAR: assert property (timer_call_s |-> !global_irq_enable
                                     && (timer_irq_flag == $past(TIMER_OVERFLOW)))
      else $error("timer service did not clear flag and enable");
   AST_TICK_FLAG_SET: assert property (tick_overflow |=> tick_irq_flag)
      else $error("tick overflow did not set the flag");
   AST_TICK_GATED: assert property (tick_call_s |-> $past(global_irq_enable && tick_irq_enable
                                    && tick_irq_flag && !CORE.stack_full))
      else $error("tick vector called without its conditions");
   AST_TICK_CLEAR: assert property (tick_call_s |-> !global_irq_enable
                                    && (tick_irq_flag == $past(tick_overflow)))
      else $error("tick service did not clear flag and enable");
   AST_WAKE: assert property ($past(CORE.sleep) && ($rose(timer_irq_flag) || $rose(tick_irq_flag))
                              |-> WAKE)
      else $error("flag rise in sleep gave no wake-up");
   AST_FLAG_HOLDS: assert property (timer_irq_flag && !take_timer && !wr_ctrl |=> timer_irq_flag)
      else $error("timer flag dropped without cause");
   AST_STACK_FULL: assert property (CORE.stack_full |=> !CALL.valid)
      else $error("interrupt acknowledged with a full stack");
   AST_RETURN_FROM_IRQ: assert property (CORE.return_from_irq && !take_any |=> global_irq_enable)
      else $error("return from interrupt did not set the global enable");
   AST_RET: assert property (CORE.ret && !CORE.return_from_irq && !wr_ctrl && !global_irq_enable
                             |=> !global_irq_enable)
      else $error("plain return changed the global enable");
   AST_PRIORITY: assert property (gated_timer_s ##0 tick_ready |=> timer_call_s)
      else $error("tick served ahead of a pending timer");
   AST_DIV_ZERO: assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == `TTI_OFS_TICK_DIV
                                  |-> (AVS_READDATA & ~32'h0000_0030) == 32'h0000_0000)
      else $error("unused divider bits read non-zero");

   // One-cycle strobes and quiet idle values on the outputs, and the tick flag hold.
   // A broken strobe here would hang a bus master or double-enter a handler.
   AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for two cycles");
   AST_READ_UPPER: assert property (AVS_READDATA[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
   AST_VEC_IDLE: assert property (!CALL.valid |-> CALL.vector == 12'h000)
      else $error("vector shown without a call");
   AST_ONE_CALL: assert property (CALL.valid |=> !CALL.valid)
      else $error("two calls in consecutive cycles");
   AST_WAKE_SLEEP: assert property (WAKE |-> $past(CORE.sleep))
      else $error("wake-up pulse outside sleep");
   AST_TICK_HOLDS: assert property (tick_irq_flag && !take_tick && !wr_ctrl |=> tick_irq_flag)
      else $error("tick flag dropped without cause");
endmodule
`default_nettype wire

// ==== tti_core_model.sv ====
// Behavioural model of the core's program sequencer and return stack.
`timescale 1ns/10ps
`default_nettype none
module tti_core_model #(
   parameter int DEPTH = 2
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire tti_pkg::tti_call_t call,
   input  wire logic               do_call,
   input  wire logic               do_ret,
   input  wire logic               do_return_from_irq,
   input  wire logic               auto_return_from_irq,
   input  wire logic               do_sleep,
   output var  tti_pkg::tti_core_t core
);
   import tti_pkg::*;
   // ****************************************************************
   // Return stack
   // ****************************************************************
   int next_depth;
   int depth;
   // A vector call pushes the program counter and nothing else; the returns pop it.
   assign next_depth = depth + int'(call.valid | do_call) - int'(core.ret | core.return_from_irq);
   // Strobes are one cycle wide; a full stack shows as a level, as the real core does.
   always_ff @(posedge clk) begin
      if (rst) begin
         depth <= 0;
         core  <= '0;
      end else begin
         depth           <= next_depth;
         core.stack_full <= next_depth >= DEPTH;
         core.ret        <= do_ret;
         core.return_from_irq       <= do_return_from_irq | (auto_return_from_irq & call.valid);
         core.sleep      <= do_sleep;
      end
   end
endmodule
`default_nettype wire

// ==== tti_timer_tick_irq_tb_top.sv ====
// Self-checking testbench of the timer and tick interrupt logic.
`timescale 1ns/10ps
`default_nettype none
`include "tti_defs.svh"
module tti_timer_tick_irq_tb_top;
   import tti_pkg::*;
   // ****************************************************************
   // Signals and reference state
   // ****************************************************************
   localparam int BASE = 64;
   logic        SYS_CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, TIMER_OVERFLOW, SUB_CLK_PIN, WAKE;
   logic        do_call, do_ret, do_return_from_irq, auto_return_from_irq, do_sleep;
   logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA;
   logic [7:0]  q, d;
   tti_core_t   core_s;
   tti_call_t   call_s;
   int          fail_count, cmp_count, cyc, sc, wake_n, w0;
   int          r_gie, r_tmr_en, r_tflag, r_tick_en, r_kflag;
   logic [11:0] got_q[$];
   int          cyc_q[$];

   tti_timer_tick_irq #(.TICK_BASE_CYCLES(BASE)) i_tti_timer_tick_irq (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .TIMER_OVERFLOW(TIMER_OVERFLOW), .SUB_CLK_PIN(SUB_CLK_PIN), .CORE(core_s), .CALL(call_s), .WAKE(WAKE));
   tti_core_model #(.DEPTH(2)) i_tti_core_model (.clk(SYS_CLK), .rst(SYS_RST), .call(call_s),
      .do_call(do_call), .do_ret(do_ret), .do_return_from_irq(do_return_from_irq), .auto_return_from_irq(auto_return_from_irq), .do_sleep(do_sleep),
      .core(core_s));

   // The clock toggles every half period of 2.5 ns.
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end

   // Sub clock of six system cycles; it runs free, as a real low-speed oscillator does.
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      sc  <= (sc == 2) ? 0 : sc + 1;
      if (sc == 2) SUB_CLK_PIN <= ~SUB_CLK_PIN;
      if (call_s.valid === 1'b1) begin
         got_q.push_back(call_s.vector);
         cyc_q.push_back(cyc);
      end
      if (WAKE === 1'b1) wake_n <= wake_n + 1;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus access; ovf pulses the timer so that it lands on the accepting edge.
   task automatic bus(input bit wr, input logic [3:0] a, input logic [7:0] dat, input logic [3:0] be,
                      input bit ovf);
      int n;
      n = 0;
      @(posedge SYS_CLK);
      AVS_ADDRESS    <= a;
      AVS_WRITEDATA  <= {24'h0000_00, dat};
      AVS_BYTEENABLE <= be;
      AVS_WRITE      <= wr;
      AVS_READ       <= !wr;
      do begin
         @(posedge SYS_CLK);
         n++;
         TIMER_OVERFLOW <= (n == 1) && ovf;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
      q = AVS_READDATA[7:0];
      AVS_WRITE <= 1'b0;
      AVS_READ  <= 1'b0;
      if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
   endtask

   function automatic logic [7:0] irq_word();
      return 8'((r_gie << `TTI_BIT_GIE) | (r_tmr_en << `TTI_BIT_TIMER_EN) | (r_tflag << `TTI_BIT_TIMER_FLAG)
              | (r_tick_en << `TTI_BIT_TICK_EN) | (r_kflag << `TTI_BIT_TICK_FLAG));
   endfunction

   task automatic set_irq(input bit ovf);
      bus(1'b1, `TTI_OFS_IRQ_CTRL, irq_word(), 4'hF, ovf);
   endtask

   // The tick flag is masked: the free-running divider may set it at any moment.
   task automatic chk_irq();
      bus(1'b0, `TTI_OFS_IRQ_CTRL, 8'h00, 4'hF, 1'b0);
      chk(32'(q & 8'hEF), 32'(irq_word() & 8'hEF));
   endtask

   // Kinds: 0 plain call, 1 return, 2 return from interrupt, 3 timer overflow.
   task automatic cmd(input int k);
      @(posedge SYS_CLK);
      case (k)
         0: do_call <= 1'b1;
         1: do_ret <= 1'b1;
         2: do_return_from_irq <= 1'b1;
         default: TIMER_OVERFLOW <= 1'b1;
      endcase
      @(posedge SYS_CLK);
      {do_call, do_ret, do_return_from_irq, TIMER_OVERFLOW} <= 4'h0;
   endtask

   task automatic wait_call(input logic [11:0] v);
      int n;
      n = 0;
      while (got_q.size() == 0 && n < 4000) begin
         @(posedge SYS_CLK);
         n++;
      end
      if (got_q.size() == 0) chk(32'h0000_DEAD, 32'(v));
      else chk(32'(got_q.pop_front()), 32'(v));
   endtask

   task automatic no_call(input int n);
      repeat (n) @(posedge SYS_CLK);
      chk(32'(got_q.size()), 32'h0000_0000);
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // A hang counts as a mismatch and ends the run in the same place.
   initial begin
      repeat (80000) @(posedge SYS_CLK);
      fail_count++;
      report_and_stop();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {SYS_RST, AVS_READ, AVS_WRITE, TIMER_OVERFLOW, SUB_CLK_PIN} = 5'b10000;
      {do_call, do_ret, do_return_from_irq, auto_return_from_irq, do_sleep} = 5'b00000;
      {AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA} = '0;
      {cyc, sc, wake_n, fail_count, cmp_count} = '0;
      {r_gie, r_tmr_en, r_tflag, r_tick_en, r_kflag} = '0;
      void'($urandom(32'hbefc9f7f));
      repeat (20) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      // Reset values, an unmapped place and the read-as-zero bits.
      bus(1'b0, `TTI_OFS_IRQ_CTRL, 8'h00, 4'hF, 1'b0);
      chk(32'(q), 32'h0000_0000);
      got_q.delete();
      for (int a = 1; a < 4; a++) begin
         bus(1'b0, 4'(a * 4), 8'h00, 4'hF, 1'b0);
         chk(32'(q), 32'h0000_0000);
      end
      bus(1'b1, 4'h2, 8'hFF, 4'hF, 1'b0);
      bus(1'b0, 4'h2, 8'h00, 4'hF, 1'b0);
      chk(32'(q), 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         bus(1'b1, `TTI_OFS_TICK_DIV, d, 4'hF, 1'b0);
         bus(1'b0, `TTI_OFS_TICK_DIV, 8'h00, 4'hF, 1'b0);
         chk(32'(q), 32'(d & `TTI_PERIOD_MASK));
      end
      bus(1'b1, `TTI_OFS_TICK_DIV, ~d, 4'h0, 1'b0);
      bus(1'b0, `TTI_OFS_TICK_DIV, 8'h00, 4'hF, 1'b0);
      chk(32'(q), 32'(d & `TTI_PERIOD_MASK));
      bus(1'b1, `TTI_OFS_TICK_DIV, 8'h00, 4'hF, 1'b0);
      // Timer path: enables, entry, the two kinds of return.
      r_gie = 1;
      set_irq(1'b0);
      cmd(3);
      r_tflag = 1;
      no_call(10);
      chk_irq();
      r_tmr_en = 1;
      set_irq(1'b0);
      wait_call(`TTI_VEC_TIMER);
      {r_gie, r_tflag} = '0;
      chk_irq();
      cmd(2);
      r_gie = 1;
      chk_irq();
      cmd(3);
      wait_call(`TTI_VEC_TIMER);
      r_gie = 0;
      cmd(1);
      chk_irq();
      cmd(3);
      r_tflag = 1;
      no_call(10);
      chk_irq();
      // A software clear that meets an overflow loses; alone it clears.
      r_tflag = 0;
      set_irq(1'b1);
      r_tflag = 1;
      chk_irq();
      r_tflag = 0;
      set_irq(1'b0);
      chk_irq();
      // Full stack holds an enabled request until a return frees a slot.
      cmd(0);
      cmd(0);
      r_gie = 1;
      set_irq(1'b0);
      cmd(3);
      no_call(20);
      r_tflag = 1;
      chk_irq();
      cmd(1);
      wait_call(`TTI_VEC_TIMER);
      cmd(2);
      cmd(1);
      r_tflag = 0;
      chk_irq();
      // Both pending: timer first, the tick only after the return re-enables.
      {r_gie, r_tmr_en, r_tflag, r_tick_en, r_kflag} = {32'd0, 32'd1, 32'd1, 32'd1, 32'd1};
      set_irq(1'b0);
      r_gie = 1;
      set_irq(1'b0);
      wait_call(`TTI_VEC_TIMER);
      no_call(8);
      cmd(2);
      wait_call(`TTI_VEC_TICK);
      {r_gie, r_tflag, r_kflag} = '0;
      chk_irq();
      cmd(2);
      r_gie = 1;
      // Tick period for each source and period code; the service returns at once.
      for (int s = 0; s < 2; s++) begin
         for (int p = 0; p < 4; p++) begin
            bus(1'b1, `TTI_OFS_TIMER_CTRL, 8'(s), 4'hF, 1'b0);
            bus(1'b1, `TTI_OFS_TICK_DIV, 8'(p << `TTI_PERIOD_LSB), 4'hF, 1'b0);
            auto_return_from_irq <= 1'b1;
            r_tick_en = 1;
            set_irq(1'b0);
            got_q.delete();
            cyc_q.delete();
            repeat (3) wait_call(`TTI_VEC_TICK);
            if (cyc_q.size() >= 3) chk(32'(cyc_q[2] - cyc_q[1]), 32'((BASE << p) * (s ? 6 : 1)));
            r_tick_en = 0;
            set_irq(1'b0);
            repeat (4) @(posedge SYS_CLK);
            auto_return_from_irq <= 1'b0;
         end
      end
      bus(1'b1, `TTI_OFS_TICK_DIV, 8'h00, 4'hF, 1'b0);
      bus(1'b1, `TTI_OFS_TIMER_CTRL, 8'h00, 4'hF, 1'b0);
      // Wake-up in sleep with the global and tick enables off; a preset flag stays silent.
      {r_gie, r_kflag} = {32'd0, 32'd1};
      set_irq(1'b0);
      do_sleep <= 1'b1;
      w0 = wake_n;
      repeat (200) @(posedge SYS_CLK);
      chk(32'(wake_n - w0), 32'h0000_0000);
      cmd(3);
      repeat (4) @(posedge SYS_CLK);
      chk(32'(wake_n - w0), 32'h0000_0001);
      {r_tflag, r_kflag} = {32'd1, 32'd0};
      set_irq(1'b0);
      repeat (100) @(posedge SYS_CLK);
      chk(32'(wake_n - w0), 32'h0000_0002);
      do_sleep <= 1'b0;
      report_and_stop();
   end
endmodule
`default_nettype wire
